// file: pkg/pmseq_pkg.sv
/*
 Constants, types and register map shared by both ends of the power
 monitor ADC sequencer link.
 Assumes nothing beyond a SystemVerilog compiler; no timescale here.
*/
// What this block does
// RL1 - Scan sense, supply, auxiliary in fixed order
// RL2 - Sense code step is 25uV, 102.4mV
// RL3 - Supply code step is 25mV, 102.4V
// RL4 - Auxiliary code step is 0.5mV, 2.048V
// RL5 - Result split: eight high, four low bits
// RL6 - Low result byte bottom nibble reads zero
// RL7 - Result registers refresh at each conversion end
// RL8 - Host writes snapshot enable and channel once
// RL9 - Snapshot starts after write; busy flag set
// RL10 - Snapshot end halts ADC, clears busy
// RL11 - Each new snapshot needs a control rewrite
// RL12 - Either supply above lockout enables logic
// RL13 - Both supplies low disable ADC, reset logic
// RL14 - Shutdown bit powers down ADC and reference
// RL15 - Shutdown keeps link, freezes latched address
// RL16 - Registers kept and accessible during shutdown
// RL17 - Clearing shutdown bit resumes conversions
// RL18 - Shutdown turns regulator output off
// RL19 - Host avoids shutdown when regulator feeds bus
// RL20 - Idle-free endless scan unless snapshot or shutdown
package pmseq_pkg;

   typedef logic [1:0] pmseq_chan_t;
   typedef logic [5:0] pmseq_addr_t;

   localparam int unsigned SYNC_N   = 8;
   localparam int unsigned RES_W    = 12;
   localparam int unsigned N_CHAN   = 3;

   // Device register offsets
   localparam pmseq_addr_t REG_CTRL    = 6'h00;
   localparam pmseq_addr_t REG_SNS_MSB = 6'h01;
   localparam pmseq_addr_t REG_SNS_LSB = 6'h02;
   localparam pmseq_addr_t REG_VIN_MSB = 6'h03;
   localparam pmseq_addr_t REG_VIN_LSB = 6'h04;
   localparam pmseq_addr_t REG_AUX_MSB = 6'h05;
   localparam pmseq_addr_t REG_AUX_LSB = 6'h06;

   // Control register fields
   localparam int unsigned CTRL_SNAP_EN  = 7;
   localparam int unsigned CTRL_SEL_HI   = 6;
   localparam int unsigned CTRL_SEL_LO   = 5;
   localparam int unsigned CTRL_BUSY     = 3;
   localparam int unsigned CTRL_VSRC_HI  = 2;
   localparam int unsigned CTRL_SHDN     = 1;
   localparam int unsigned CTRL_VSRC_LO  = 0;
   localparam logic [7:0]  CTRL_RST      = 8'h05;
   localparam logic [7:0]  CTRL_WMASK    = 8'he7;

   // Channel codes
   localparam pmseq_chan_t CH_SENSE = 2'h0;
   localparam pmseq_chan_t CH_VIN   = 2'h1;
   localparam pmseq_chan_t CH_AUX   = 2'h2;

   // Host APB registers
   localparam logic [31:0] HOST_CMD     = 32'h0000_0000;
   localparam logic [31:0] HOST_STAT    = 32'h0000_0004;
   localparam int unsigned CMD_WDATA_LO = 0;
   localparam int unsigned CMD_ADDR_LO  = 8;
   localparam int unsigned CMD_WRITE    = 16;
   localparam int unsigned STAT_BUSY    = 0;
   localparam int unsigned STAT_RD_LO   = 8;

   typedef enum {DS_IDLE, DS_CONV} pmseq_dev_st_t;
   typedef enum {HS_IDLE, HS_REQ}  pmseq_host_st_t;

endpackage : pmseq_pkg

// file: pkg/pmseq_link_if.sv
/*
 Register link between host controller end and monitor device end.
 Assumes one shared clock; both ends drive only from flip-flops.
*/
`timescale 1ns/10ps
interface pmseq_link_if;
   logic       req;
   logic       wr;
   logic [5:0] addr;
   logic [7:0] wdata;
   logic       ack;
   logic [7:0] rdata;

   modport dev  (input req, wr, addr, wdata, output ack, rdata);
   modport host (output req, wr, addr, wdata, input ack, rdata);
endinterface : pmseq_link_if

// file: rtl/pmseq_dev_end.sv
/*
 Device end: control and result registers, conversion sequencer,
 supply lockout, shutdown, address latch.
 Assumes an ADC that takes a start pulse and returns one done pulse
 with data on pclk; supply and address pins are asynchronous.
*/
// Added by the designer: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
module pmseq_dev_end (
   input  wire logic               pclk,
   input  wire logic               presetn,
   pmseq_link_if.dev               link,
   output      logic               adc_start_q,
   output      pmseq_pkg::pmseq_chan_t adc_chan_q,
   input  wire logic               adc_done,
   input  wire logic [11:0]        adc_data,
   output      logic               adc_pwr_q,
   output      logic               adc_vdd_sel_q,
   output      logic               reg_en_q,
   output      logic               logic_alive_q,
   input  wire logic               high_voltage_supply_ok,
   input  wire logic               internal_low_supply_ok,
   input  wire logic               high_voltage_supply_live,
   input  wire logic               internal_low_supply_live,
   input  wire logic [1:0]         address_select_hi,
   input  wire logic [1:0]         address_select_lo,
   output      logic [3:0]         bus_addr_q
);
   import pmseq_pkg::*;

   // Channel index of a result register, or 3 when none
   function automatic pmseq_chan_t res_chan(input pmseq_addr_t a);
      unique case (a)
         REG_SNS_MSB, REG_SNS_LSB: res_chan = CH_SENSE;
         REG_VIN_MSB, REG_VIN_LSB: res_chan = CH_VIN;
         REG_AUX_MSB, REG_AUX_LSB: res_chan = CH_AUX;
         default:                  res_chan = 2'h3;
      endcase
   endfunction : res_chan

   // Selector code 3 has no channel of its own; it converts auxiliary
   function automatic pmseq_chan_t sel_chan(input pmseq_chan_t s);
      sel_chan = (s == 2'h3) ? CH_AUX : s;
   endfunction : sel_chan

   logic [SYNC_N-1:0] s1_q;
   logic [SYNC_N-1:0] s2_q;
   logic [SYNC_N-1:0] s3_q;
   logic [SYNC_N-1:0] filt_q;
   logic [SYNC_N-1:0] filt_d;
   logic [SYNC_N-1:0] pins;
   logic [7:0]        ctrl_q;
   logic              busy_q;
   logic              pend_q;
   logic              cur_snap_q;
   pmseq_chan_t       scan_q;
   pmseq_dev_st_t     st_q;
   logic [RES_W-1:0]  res_q [N_CHAN];
   logic              ack_q;
   logic [7:0]        rdata_q;

   wire hv_ok   = filt_q[0];
   wire lv_ok   = filt_q[1];
   wire hv_live = filt_q[2];
   wire lv_live = filt_q[3];
   wire [3:0] adr_pins = filt_q[7:4];

   assign pins   = {address_select_hi, address_select_lo,
                    internal_low_supply_live, high_voltage_supply_live,
                    internal_low_supply_ok, high_voltage_supply_ok};
   // A change counts only once the second and third stages agree
   assign filt_d = ((s2_q ~^ s3_q) & s2_q) | ((s2_q ^ s3_q) & filt_q);

   wire adc_en   = hv_ok | lv_ok; // RL12 RL13
   wire shdn     = ctrl_q[CTRL_SHDN];
   wire run      = adc_en & logic_alive_q & ~shdn; // RL14 RL17
   wire snap_en  = ctrl_q[CTRL_SNAP_EN];
   wire take     = link.req & ~ack_q & logic_alive_q;
   wire wr_take  = take & link.wr;
   wire ctrl_wr  = wr_take & (link.addr == REG_CTRL);
   wire snap_wr  = ctrl_wr & link.wdata[CTRL_SNAP_EN]; // RL9 RL11
   wire pmseq_chan_t snap_ch =
      sel_chan({ctrl_q[CTRL_SEL_HI], ctrl_q[CTRL_SEL_LO]});
   wire pmseq_chan_t rd_ch = res_chan(link.addr);
   wire rd_msb = link.addr[0];
   wire start  = (st_q == DS_IDLE) & run & (pend_q | ~snap_en); // RL20
   wire done   = (st_q == DS_CONV) & run & adc_done;
   wire abort  = (st_q == DS_CONV) & ~run;
   wire [7:0] ctrl_rd = {ctrl_q[7:4], busy_q, ctrl_q[2:0]};
   wire [7:0] res_rd  = (rd_ch == 2'h3) ? 8'h00 :
      rd_msb ? res_q[rd_ch][11:4] : {res_q[rd_ch][3:0], 4'h0}; // RL5 RL6
   wire [7:0] rd_mux  = (link.addr == REG_CTRL) ? ctrl_rd : res_rd;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q   <= '0;
         s2_q   <= '0;
         s3_q   <= '0;
         filt_q <= '0;
      end else begin
         s1_q   <= pins;
         s2_q   <= s1_q;
         s3_q   <= s2_q;
         filt_q <= filt_d;
      end
   end

   // Logic stays up until both supplies drop below the reset level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         logic_alive_q <= 1'b0;
      end else if (adc_en) begin
         logic_alive_q <= 1'b1; // RL12
      end else if (!hv_live && !lv_live) begin
         logic_alive_q <= 1'b0; // RL13
      end
   end

   // Link answer one cycle after the request is taken
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_q   <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         ack_q <= take; // RL16
         if (take) begin
            rdata_q <= rd_mux;
         end
      end
   end

   // Control register and snapshot bookkeeping
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q     <= CTRL_RST;
         busy_q     <= 1'b0;
         pend_q     <= 1'b0;
         cur_snap_q <= 1'b0;
      end else if (!logic_alive_q) begin
         ctrl_q     <= CTRL_RST; // RL13
         busy_q     <= 1'b0;
         pend_q     <= 1'b0;
         cur_snap_q <= 1'b0;
      end else begin
         if (start) begin
            cur_snap_q <= pend_q;
            pend_q     <= 1'b0;
         end
         // A snapshot still queued behind this one keeps busy up
         if (done && cur_snap_q && !pend_q) begin
            busy_q <= 1'b0; // RL10
         end
         // A snapshot cut short by supply lockout runs again when a supply returns; after shutdown the wake-up write's snapshot enable decides
         if (abort && cur_snap_q) begin
            pend_q <= 1'b1;
         end
         if (ctrl_wr) begin
            ctrl_q <= link.wdata & CTRL_WMASK; // RL16 RL17
            busy_q <= snap_wr; // RL9
            pend_q <= snap_wr; // RL11
         end
      end
   end

   // Sequencer: one conversion at a time, result stored at its end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q        <= DS_IDLE;
         scan_q      <= CH_SENSE;
         adc_start_q <= 1'b0;
         adc_chan_q  <= CH_SENSE;
      end else begin
         adc_start_q <= start;
         unique case (st_q)
            DS_IDLE: begin
               if (start) begin
                  adc_chan_q <= pend_q ? snap_ch : scan_q; // RL1
                  st_q       <= DS_CONV;
               end
            end
            DS_CONV: begin
               if (abort) begin
                  st_q <= DS_IDLE; // RL14
               end else if (done) begin
                  st_q <= DS_IDLE;
                  if (!cur_snap_q) begin
                     scan_q <= (scan_q == CH_AUX) ? CH_SENSE :
                        pmseq_chan_t'(scan_q + 2'h1); // RL1 RL20
                  end
               end
            end
         endcase
      end
   end

   // Results; a finished conversion beats a same-cycle host write.
   // Codes are raw 12-bit steps: 25uV sense, 25mV supply, 0.5mV aux.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < N_CHAN; i++) begin
            res_q[i] <= '0;
         end
      end else begin
         for (int i = 0; i < N_CHAN; i++) begin
            if (done && adc_chan_q == pmseq_chan_t'(i)) begin
               res_q[i] <= adc_data; // RL2 RL3 RL4 RL7
            end else if (wr_take && rd_ch == pmseq_chan_t'(i)) begin
               if (rd_msb) begin
                  res_q[i][11:4] <= link.wdata; // RL5
               end else begin
                  res_q[i][3:0] <= link.wdata[7:4]; // RL5 RL6
               end
            end
         end
      end
   end

   // Power outputs and the address latch frozen in shutdown
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_pwr_q     <= 1'b0;
         adc_vdd_sel_q <= 1'b0;
         reg_en_q      <= 1'b1;
         bus_addr_q    <= 4'h0;
      end else begin
         adc_pwr_q     <= run; // RL14 RL17
         adc_vdd_sel_q <= ~ctrl_q[CTRL_VSRC_HI] & ctrl_q[CTRL_VSRC_LO];
         reg_en_q      <= ~shdn; // RL18
         if (!shdn) begin
            bus_addr_q <= adr_pins; // RL15
         end
      end
   end

   assign link.ack   = ack_q;
   assign link.rdata = rdata_q;

endmodule : pmseq_dev_end

// file: rtl/pmseq_host_end.sv
/*
 Host end: APB slave with a command and a status register; each
 command runs one register access over the link.
 Assumes APB on pclk; the device end answers every taken request.
*/
`timescale 1ns/10ps
module pmseq_host_end (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output      logic [31:0] prdata,
   output      logic        pready,
   output      logic        pslverr,
   pmseq_link_if.host       link
);
   import pmseq_pkg::*;

   pmseq_host_st_t st_q;
   logic           req_q;
   logic           wr_q;
   pmseq_addr_t    addr_q;
   logic [7:0]     wdata_q;
   logic [7:0]     last_rd_q;
   logic [31:0]    prdata_q;
   logic           pready_q;
   logic           pslverr_q;

   wire setup   = psel & ~penable;
   wire hit_cmd = (paddr == HOST_CMD);
   wire hit_st  = (paddr == HOST_STAT);
   wire busy    = (st_q != HS_IDLE);
   wire [31:0] stat_rd = {16'h0000, last_rd_q, 7'h00, busy};
   wire [31:0] rd_mux  = hit_st ? stat_rd : 32'h0000_0000;
   // A command written while busy is dropped; poll status first
   wire cmd_go  = psel & penable & pready_q & pwrite & hit_cmd & ~busy;

   // Every access finishes with no wait state after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~(hit_cmd | hit_st);
         prdata_q  <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // One link request at a time, held until acknowledged
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q      <= HS_IDLE;
         req_q     <= 1'b0;
         wr_q      <= 1'b0;
         addr_q    <= REG_CTRL;
         wdata_q   <= 8'h00;
         last_rd_q <= 8'h00;
      end else begin
         unique case (st_q)
            HS_IDLE: begin
               if (cmd_go) begin
                  req_q   <= 1'b1; // RL8 RL11 RL17
                  wr_q    <= pwdata[CMD_WRITE];
                  addr_q  <= pwdata[CMD_ADDR_LO +: 6];
                  wdata_q <= pwdata[CMD_WDATA_LO +: 8];
                  st_q    <= HS_REQ;
               end
            end
            HS_REQ: begin
               if (link.ack) begin
                  req_q     <= 1'b0;
                  last_rd_q <= link.rdata;
                  st_q      <= HS_IDLE;
               end
            end
         endcase
      end
   end

   assign prdata     = prdata_q;
   assign pready     = pready_q;
   assign pslverr    = pslverr_q;
   assign link.req   = req_q;
   assign link.wr    = wr_q;
   assign link.addr  = addr_q;
   assign link.wdata = wdata_q;

endmodule : pmseq_host_end

// file: test/pmseq_chk.sv
/*
 Checker for the register link between host end and device end.
 Assumes one clock and reset; sees only the link signals.
*/
`timescale 1ns/10ps
module pmseq_chk (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       req,
   input wire logic       wr,
   input wire logic [5:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       ack,
   input wire logic [7:0] rdata
);
   import pmseq_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_wait; req && !ack; endsequence
   wire lsb_w = addr == REG_SNS_LSB || addr == REG_VIN_LSB ||
                addr == REG_AUX_LSB;
   sequence s_rd_lsb; ack && !wr && lsb_w; endsequence
   sequence s_rd_unmap; ack && !wr && addr > REG_AUX_LSB; endsequence
   ack_cause_a: assert property (ack |-> $past(req))
      else $error("ack without request");
   ack_pulse_a: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   ack_time_a: assert property ($rose(req) |=> ack)
      else $error("ack not one cycle after request");
   req_hold_a: assert property (s_wait |=> req && $stable(addr) &&
      $stable(wr) && $stable(wdata)) else $error("request not held");
   req_drop_a: assert property (ack |=> !req)
      else $error("request kept after ack");
   lsb_zero_a: assert property (s_rd_lsb |-> rdata[3:0] == 4'h0)
      else $error("low result nibble not zero");
   unmap_read_a: assert property (s_rd_unmap |-> rdata == 8'h00)
      else $error("unmapped offset not zero");
   rd_hold_a: assert property ($changed(rdata) |-> ack)
      else $error("read byte changed without ack");
endmodule : pmseq_chk

// file: test/testbench.sv
/*
 Testbench: host end and device end joined by one link, with a
 behavioural ADC that answers each start pulse after 40 cycles.
 Assumes package and interface are compiled first.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
   $display("Error %s expected %0h seen %0h", n, e, g); end end
module testbench;
   import pmseq_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata;
   logic        adc_start_q, adc_done, adc_pwr_q, adc_vdd_sel_q;
   logic        reg_en_q, logic_alive_q, hv_ok, in_ok, hv_live, in_live;
   logic [11:0] adc_data;
   logic [1:0]  a_hi, a_lo, cch;
   logic [3:0]  bus_addr_q;
   pmseq_chan_t adc_chan_q;
   pmseq_chan_t starts[$];
   int          cnt = 0;
   int          n_errors = 0;
   int          checked = 0;
   pmseq_link_if link_if();
   pmseq_host_end pmseq_host_end_inst (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .link(link_if.host));
   pmseq_dev_end pmseq_dev_end_inst (.pclk(pclk), .presetn(presetn),
      .link(link_if.dev), .adc_start_q(adc_start_q),
      .adc_chan_q(adc_chan_q), .adc_done(adc_done), .adc_data(adc_data),
      .adc_pwr_q(adc_pwr_q), .adc_vdd_sel_q(adc_vdd_sel_q),
      .reg_en_q(reg_en_q), .logic_alive_q(logic_alive_q),
      .high_voltage_supply_ok(hv_ok), .internal_low_supply_ok(in_ok),
      .high_voltage_supply_live(hv_live),
      .internal_low_supply_live(in_live), .address_select_hi(a_hi),
      .address_select_lo(a_lo), .bus_addr_q(bus_addr_q));
   pmseq_chk pmseq_chk_inst (.pclk(pclk), .presetn(presetn),
      .req(link_if.req), .wr(link_if.wr), .addr(link_if.addr),
      .wdata(link_if.wdata), .ack(link_if.ack), .rdata(link_if.rdata));
   function automatic logic [11:0] dat(input logic [1:0] c);
      return 12'h9a5 + 12'h111 * c;
   endfunction : dat
   // A restart cancels the conversion in flight; power loss drops done
   always @(posedge pclk) begin
      adc_done <= 1'b0;
      if (adc_start_q === 1'b1) begin
         cnt <= 40;
         cch <= adc_chan_q;
         starts.push_back(adc_chan_q);
      end else if (cnt == 1) begin
         adc_done <= adc_pwr_q;
         adc_data <= dat(cch);
         cnt <= 0;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask : tick
   task automatic apb(input logic w, input logic [31:0] a, d,
                      output logic [31:0] r, output logic e);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic lnk(input logic w, input pmseq_addr_t a,
                      input logic [7:0] d, output logic [7:0] q);
      logic [31:0] r;
      logic        e;
      apb(1'b1, HOST_CMD, {15'h0, w, 2'h0, a, d}, r, e);
      do apb(1'b0, HOST_STAT, 32'h0, r, e); while (r[STAT_BUSY] !== 1'b0);
      q = r[15:8];
   endtask : lnk
   task automatic rd(input pmseq_addr_t a, input logic [7:0] x,
                     input string n);
      logic [7:0] q;
      lnk(1'b0, a, 8'h00, q);
      `CHK(n, x, q)
   endtask : rd
   task automatic t_regs;
      logic [31:0] r;
      logic        e;
      rd(REG_CTRL, CTRL_RST, "ctrl reset");
      rd(6'h3f, 8'h00, "unmapped link");
      apb(1'b0, 32'h0000_0008, 32'h0, r, e);
      `CHK("apb error", 1'b1, e)
   endtask : t_regs
   task automatic t_scan;
      logic [11:0] v;
      starts.delete();
      tick(200);
      `CHK("scan count", 1'b1, starts.size() >= 4)
      for (int i = 0; i < 3; i++)
         `CHK("scan order", (starts[i] + 1) % 3, starts[i + 1])
      for (int c = 0; c < 3; c++) begin
         v = dat(2'(c));
         rd(REG_SNS_MSB + 6'(2 * c), v[11:4], "result msb");
         rd(REG_SNS_LSB + 6'(2 * c), {v[3:0], 4'h0}, "result lsb");
      end
   endtask : t_scan
   task automatic t_snap;
      logic [7:0] c, q;
      for (int s = 0; s < 4; s++) begin
         c = 8'h85 | 8'(s << 5);
         starts.delete();
         lnk(1'b1, REG_CTRL, c, q);
         rd(REG_CTRL, c | 8'h08, "busy set");
         tick(80);
         rd(REG_CTRL, c, "busy clear");
         `CHK("snap ran", 1'b1, starts.size() > 0)
         `CHK("snap chan", (s == 3) ? CH_AUX : 2'(s), starts[$])
         starts.delete();
         tick(100);
         `CHK("halted", 0, starts.size())
      end
   endtask : t_snap
   task automatic t_shdn;
      logic [7:0] q;
      // No link logic here hangs off the regulator, so shutdown is safe
      lnk(1'b1, REG_CTRL, 8'h07, q);
      a_hi <= 2'h3;
      a_lo <= 2'h0;
      starts.delete();
      tick(100);
      `CHK("adc power", 1'b0, adc_pwr_q)
      `CHK("regulator", 1'b0, reg_en_q)
      `CHK("bus addr", 4'h6, bus_addr_q)
      `CHK("no conv", 0, starts.size())
      rd(REG_AUX_MSB, 8'hbc, "kept");
      lnk(1'b1, REG_AUX_MSB, 8'h12, q);
      rd(REG_AUX_MSB, 8'h12, "writable");
      lnk(1'b1, REG_CTRL, 8'h01, q);
      tick(100);
      `CHK("adc power", 1'b1, adc_pwr_q)
      `CHK("vdd sel", 1'b1, adc_vdd_sel_q)
      `CHK("resumed", 1'b1, starts.size() > 0)
      `CHK("bus addr", 4'hc, bus_addr_q)
   endtask : t_shdn
   task automatic t_lock;
      hv_ok <= 1'b1;
      in_ok <= 1'b0;
      tick(10);
      `CHK("adc on", 1'b1, adc_pwr_q)
      hv_ok <= 1'b0;
      tick(10);
      `CHK("adc off", 1'b0, adc_pwr_q)
      `CHK("logic kept", 1'b1, logic_alive_q)
      hv_live <= 1'b0;
      in_live <= 1'b0;
      tick(10);
      `CHK("logic off", 1'b0, logic_alive_q)
   endtask : t_lock
   task automatic complete_run;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : complete_run
   initial begin
      repeat (40000) @(posedge pclk);
      n_errors++;
      complete_run;
   end
   // Only one supply good at start: either one must wake the logic
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {hv_ok, in_ok, hv_live, in_live} = 4'b0111;
      a_hi = 2'h1;
      a_lo = 2'h2;
      adc_done = 1'b0;
      adc_data = 12'h000;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      tick(10);
      `CHK("alive", 1'b1, logic_alive_q)
      `CHK("bus addr", 4'h6, bus_addr_q)
      `CHK("vdd sel", 1'b0, adc_vdd_sel_q)
      t_regs;
      t_scan;
      t_snap;
      t_shdn;
      t_lock;
      complete_run;
   end
   initial forever #2.5 pclk = ~pclk;
endmodule : testbench
